// ---- double_reg.sv ----
// Purpose: One double register, upper and lower rows with paired clears and gates
// Assumes: Commands come from logic on the same clock
// Notes: Gate polarity is opposite to the clear that precedes it
`timescale 1ns/1ps
module double_reg #(
    parameter int WIDTH = shift_pkg::ROW_W,
    parameter bit UP_ONES = 1'b1,
    parameter bit ENTRY_TO_LOWER = 1'b0
) (
    // Clock and reset
    input wire logic clock_in,
    input wire logic rstn_in,
    // Commands
    input wire shift_pkg::dreg_cmd_t cmd_in,
    input wire logic strobe_in,
    input wire logic direct_in,
    // Data in
    input wire logic [WIDTH-1:0] entry_word_in,
    input wire logic serial_valid_in,
    input wire logic serial_bit_in,
    // Rows
    output logic [WIDTH-1:0] upper_out,
    output logic [WIDTH-1:0] lower_out
);
    import shift_pkg::*;

    typedef struct packed {
        logic [WIDTH-1:0] upper;
        logic [WIDTH-1:0] lower;
    } row_pair_t;

    row_pair_t s;
    row_pair_t next_s;

    // Columns outside mask keep their cleared value (vacated shift column)
    function automatic logic [WIDTH-1:0] merge(input logic [WIDTH-1:0] dst, input logic [WIDTH-1:0] src,
                                               input logic [WIDTH-1:0] mask, input logic ones, input logic dir);
        if (dir) begin
            merge = (dst & ~mask) | (src & mask);
        end else if (ones) begin
            merge = dst | (src & mask);
        end else begin
            merge = dst & (src | ~mask);
        end
    endfunction

    localparam logic [WIDTH-1:0] ALL = '1;

    always_comb begin
        next_s = s;
        // Upper clears: ones side, then zeros side
        if (cmd_in.clr_up_ones && UP_ONES) begin
            next_s.upper = '1;
        end
        if (cmd_in.clr_up_zeros) begin
            next_s.upper = '0;
        end
        if (cmd_in.clr_lo_zeros) begin
            next_s.lower = '0;
        end
        if (cmd_in.clr_lo_ones) begin
            next_s.lower = '1;
        end
        // One gate per element side, except lower-row entry and direct_in, which gate both sides; strobe bounds every gate
        if (strobe_in) begin
            if (cmd_in.gate_copy_up) begin
                next_s.upper = merge(next_s.upper, s.lower, ALL, 1'b1, direct_in);
            end
            if (cmd_in.gate_entry && !ENTRY_TO_LOWER) begin
                next_s.upper = merge(next_s.upper, entry_word_in, ALL, 1'b0, direct_in);
            end
            if (cmd_in.gate_right) begin
                next_s.lower = merge(next_s.lower, {1'b0, s.upper[WIDTH-1:1]}, {1'b0, ALL[WIDTH-2:0]},
                                     1'b1, direct_in);
            end
            if (cmd_in.gate_left) begin
                next_s.lower = merge(next_s.lower, {s.upper[WIDTH-2:0], 1'b0}, {ALL[WIDTH-2:0], 1'b0},
                                     1'b0, direct_in);
            end
            if (cmd_in.gate_entry && ENTRY_TO_LOWER) begin
                // Both element sides gated, so no clear is needed
                next_s.lower = entry_word_in;
            end
        end
        if (serial_valid_in) begin
            next_s.lower = {next_s.lower[WIDTH-2:0], serial_bit_in};
        end
        if (!rstn_in) begin
            next_s = '0;
        end
    end

    always_ff @(posedge clock_in) begin
        s <= next_s;
    end

    assign upper_out = s.upper;
    assign lower_out = s.lower;
endmodule // double_reg

// ---- seq_model.sv ----
// Purpose: Sequencer, adder and memory stand-in
// Assumes: go pulses only while idle
// Notes: Source word reads inverted outside the gate cycle
`timescale 1ns/1ps
module seq_model (
    // Clock and reset
    input wire logic clock_in,
    input wire logic rstn_in,
    // Request
    input wire logic go_in,
    input wire logic [2:0] op_in,
    input wire logic strobe_en_in,
    input wire logic [39:0] word_in,
    // Toward the block
    output shift_pkg::seq_cmd_t cmd_out,
    output logic strobe_out,
    output logic [39:0] src_word_out
);
    import shift_pkg::*;
    logic [1:0] ph;
    logic [2:0] op;
    always_ff @(posedge clock_in) begin
        ph <= !rstn_in ? 2'h0 : go_in ? 2'h1 : {ph == 2'h1, 1'b0};
        if (go_in) begin
            op <= op_in;
        end
    end
    // Clear in one cycle, its own gate in the next
    always_comb begin
        cmd_out = seq_cmd_t'(ph == 2'h2 ? 11'h020 >> op : 11'h000);
        if (ph == 2'h1 && op < 3'h5) begin
            cmd_out = seq_cmd_t'(11'h400 >> op);
        end
    end
    assign strobe_out = ph == 2'h2 && strobe_en_in;
    assign src_word_out = ph == 2'h2 ? word_in : ~word_in;
endmodule // seq_model

// ---- shift_pkg.sv ----
// Purpose: Shared constants and carriers for the shifting double registers
// Assumes: 40-column rows, AXI4-Lite register access, one 250 MHz clock
// Notes: Register offsets are byte addresses
//
// How it works
// - Clears and gates are used as fixed pairs, one clear per gate except the memory entry gate.
// - Four clears on the first double register (two to all ones, two to zeros); three on the second, one to ones.
// - Each double register has 40-column upper and lower rows, four gates.
// - First pair right-shift-down gate moves upper into accumulator one right.
// - First pair left-shift-down gate moves upper into accumulator one left.
// - Copy-up gate copies lower row into upper row, unshifted.
// - Second pair shift gates move upper into arithmetic row, one right or left.
// - Entry gate loads the adder sum word into the first upper row.
// - Memory entry gate loads a memory word straight into the arithmetic row.
// - Second upper row has no clear to ones, only clear to zeros.
// - Tape words enter the accumulator serially at its least significant end.
// - Every memory store takes its data from the accumulator row.
// - Accumulator holds operands and receives sums and product high part.
// - Gating both element sides copies the source without a prior clear.
// - A gate acts only while its timing strobe is also active.
// - Each element side is driven by at most one gate; the arithmetic row's sides also take the memory entry gate.
// - Second pair shifts in lockstep with every shift of the first pair.
package shift_pkg;
    localparam int ROW_W = 40;
    localparam int HI_W = ROW_W - 32;
    localparam int ADDR_W = 8;
    localparam int PAIRS = 5;

    // ----------------------------------------
    // Register map
    // ----------------------------------------
    localparam logic [ADDR_W-1:0] OFS_CTRL = 8'h00;
    localparam logic [ADDR_W-1:0] OFS_CMD = 8'h04;
    localparam logic [ADDR_W-1:0] OFS_STATUS = 8'h08;
    localparam logic [ADDR_W-1:0] OFS_ACC_LO = 8'h10;
    localparam logic [ADDR_W-1:0] OFS_ACC_HI = 8'h14;
    localparam logic [ADDR_W-1:0] OFS_UP1_LO = 8'h18;
    localparam logic [ADDR_W-1:0] OFS_UP1_HI = 8'h1c;
    localparam logic [ADDR_W-1:0] OFS_ARITH_LO = 8'h20;
    localparam logic [ADDR_W-1:0] OFS_ARITH_HI = 8'h24;
    localparam logic [ADDR_W-1:0] OFS_UP2_LO = 8'h28;
    localparam logic [ADDR_W-1:0] OFS_UP2_HI = 8'h2c;
    localparam int CTRL_DIRECT = 0;
    localparam int STAT_UNPAIRED = 0;
    localparam int STAT_COLLIDE = 1;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
    localparam logic [ROW_W-1:0] ROW_RESET = '0;
    // Pair slots in the armed vector
    localparam int P_ENTRY = 0;
    localparam int P_COPY1 = 1;
    localparam int P_RIGHT = 2;
    localparam int P_LEFT = 3;
    localparam int P_COPY2 = 4;

    // ----------------------------------------
    // Carriers
    // ----------------------------------------
    typedef struct packed {
        logic entry_paired_clear;
        logic copy_up_paired_clear;
        logic right_shift_paired_clear;
        logic left_shift_paired_clear;
        logic arith_copy_up_clear;
        logic sum_entry_gate;
        logic acc_copy_up_gate;
        logic acc_right_shift_down_gate;
        logic acc_left_shift_down_gate;
        logic arith_copy_up_gate;
        logic memory_entry_gate;
    } seq_cmd_t;
    localparam int CMD_W = $bits(seq_cmd_t);

    typedef struct packed {
        logic clr_up_ones;
        logic clr_up_zeros;
        logic clr_lo_zeros;
        logic clr_lo_ones;
        logic gate_entry;
        logic gate_copy_up;
        logic gate_right;
        logic gate_left;
    } dreg_cmd_t;

    typedef struct packed {
        logic ctrl_direct;
        seq_cmd_t sw_cmd;
        logic [PAIRS-1:0] armed;
        logic unpaired;
        logic collide;
        logic aw_held;
        logic [ADDR_W-1:0] awaddr;
        logic w_held;
        logic [31:0] wdata;
        logic [3:0] wstrb;
        logic bvalid;
        logic [1:0] bresp;
        logic rvalid;
        logic [31:0] rdata;
        logic [1:0] rresp;
        logic store_valid;
        logic [ROW_W-1:0] store_data;
    } top_state_t;
endpackage

// ---- shifting_register_gating.sv ----
// Purpose: Accumulator and arithmetic double registers with AXI4-Lite access
// Assumes: Sequencer, adder, tape and memory logic share clock_in
// Notes: Software commands act as one-cycle strobed actions
`timescale 1ns/1ps
module shifting_register_gating (
    // Clock and reset
    input wire logic clock_in,
    input wire logic rstn_in,
    // Sequencer
    input wire shift_pkg::seq_cmd_t seq_cmd_in,
    input wire logic gate_strobe_in,
    // Data sources
    input wire logic [shift_pkg::ROW_W-1:0] sum_word_in,
    input wire logic [shift_pkg::ROW_W-1:0] memory_word_in,
    input wire logic tape_valid_in,
    input wire logic tape_bit_in,
    input wire logic store_strobe_in,
    // Data out
    output logic [shift_pkg::ROW_W-1:0] accumulator_row_out,
    output logic [shift_pkg::ROW_W-1:0] arithmetic_row_out,
    output logic mem_write_out,
    output logic [shift_pkg::ROW_W-1:0] mem_data_out,
    // AXI4-Lite write
    input wire logic [shift_pkg::ADDR_W-1:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    // AXI4-Lite read
    input wire logic [shift_pkg::ADDR_W-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready
);
    import shift_pkg::*;

    top_state_t s;
    top_state_t next_s;
    seq_cmd_t eff;
    logic eff_strobe;
    dreg_cmd_t cmd1;
    dreg_cmd_t cmd2;
    logic [ROW_W-1:0] upper1;
    logic [ROW_W-1:0] acc;
    logic [ROW_W-1:0] upper2;
    logic [ROW_W-1:0] arith;
    logic [PAIRS-1:0] clr_vec;
    logic [PAIRS-1:0] gate_vec;
    logic wr_go;
    logic [31:0] wmask;
    logic [31:0] rd_word;
    logic rd_hit;

    // ----------------------------------------
    // Command merge and mapping
    // ----------------------------------------
    // Software actions carry their own strobe for one cycle
    assign eff = seq_cmd_in | s.sw_cmd;
    assign eff_strobe = gate_strobe_in | (|s.sw_cmd);

    always_comb begin
        // Fixed pairs: entry/ones, copy-up/zeros, right/zeros, left/ones
        cmd1.clr_up_ones = eff.entry_paired_clear;
        cmd1.clr_up_zeros = eff.copy_up_paired_clear;
        cmd1.clr_lo_zeros = eff.right_shift_paired_clear;
        cmd1.clr_lo_ones = eff.left_shift_paired_clear;
        cmd1.gate_entry = eff.sum_entry_gate;
        cmd1.gate_copy_up = eff.acc_copy_up_gate;
        cmd1.gate_right = eff.acc_right_shift_down_gate;
        cmd1.gate_left = eff.acc_left_shift_down_gate;
        // Second pair follows every shift of the first
        cmd2.clr_up_ones = 1'b0;
        cmd2.clr_up_zeros = eff.arith_copy_up_clear;
        cmd2.clr_lo_zeros = eff.right_shift_paired_clear;
        cmd2.clr_lo_ones = eff.left_shift_paired_clear;
        cmd2.gate_entry = eff.memory_entry_gate;
        cmd2.gate_copy_up = eff.arith_copy_up_gate;
        cmd2.gate_right = eff.acc_right_shift_down_gate;
        cmd2.gate_left = eff.acc_left_shift_down_gate;
    end

    // ----------------------------------------
    // Double registers
    // ----------------------------------------
    double_reg #(.WIDTH(ROW_W), .UP_ONES(1'b1), .ENTRY_TO_LOWER(1'b0)) first_pair (
        .clock_in(clock_in),
        .rstn_in(rstn_in),
        .cmd_in(cmd1),
        .strobe_in(eff_strobe),
        .direct_in(s.ctrl_direct),
        .entry_word_in(sum_word_in),
        .serial_valid_in(tape_valid_in),
        .serial_bit_in(tape_bit_in),
        .upper_out(upper1),
        .lower_out(acc)
    );

    double_reg #(.WIDTH(ROW_W), .UP_ONES(1'b0), .ENTRY_TO_LOWER(1'b1)) second_double_register (
        .clock_in(clock_in),
        .rstn_in(rstn_in),
        .cmd_in(cmd2),
        .strobe_in(eff_strobe),
        .direct_in(s.ctrl_direct),
        .entry_word_in(memory_word_in),
        .serial_valid_in(1'b0),
        .serial_bit_in(1'b0),
        .upper_out(upper2),
        .lower_out(arith)
    );

    // Accumulator feeds the adder and every store
    assign accumulator_row_out = acc;
    assign arithmetic_row_out = arith;
    assign mem_write_out = s.store_valid;
    assign mem_data_out = s.store_data;

    // ----------------------------------------
    // Pair tracking
    // ----------------------------------------
    assign clr_vec = {eff.arith_copy_up_clear, eff.left_shift_paired_clear, eff.right_shift_paired_clear,
                      eff.copy_up_paired_clear, eff.entry_paired_clear};
    assign gate_vec = {eff.arith_copy_up_gate, eff.acc_left_shift_down_gate, eff.acc_right_shift_down_gate,
                       eff.acc_copy_up_gate, eff.sum_entry_gate} & {PAIRS{eff_strobe}};

    // ----------------------------------------
    // Register read decode
    // ----------------------------------------
    function automatic logic [31:0] hi_word(input logic [ROW_W-1:0] row);
        hi_word = {{(32 - HI_W){1'b0}}, row[ROW_W-1:32]};
    endfunction

    always_comb begin
        rd_hit = 1'b1;
        rd_word = '0;
        if (s_axi_araddr == OFS_CTRL) begin
            rd_word[CTRL_DIRECT] = s.ctrl_direct;
        end else if (s_axi_araddr == OFS_CMD) begin
            rd_word = '0;
        end else if (s_axi_araddr == OFS_STATUS) begin
            rd_word[STAT_UNPAIRED] = s.unpaired;
            rd_word[STAT_COLLIDE] = s.collide;
        end else if (s_axi_araddr == OFS_ACC_LO) begin
            rd_word = acc[31:0];
        end else if (s_axi_araddr == OFS_ACC_HI) begin
            rd_word = hi_word(acc);
        end else if (s_axi_araddr == OFS_UP1_LO) begin
            rd_word = upper1[31:0];
        end else if (s_axi_araddr == OFS_UP1_HI) begin
            rd_word = hi_word(upper1);
        end else if (s_axi_araddr == OFS_ARITH_LO) begin
            rd_word = arith[31:0];
        end else if (s_axi_araddr == OFS_ARITH_HI) begin
            rd_word = hi_word(arith);
        end else if (s_axi_araddr == OFS_UP2_LO) begin
            rd_word = upper2[31:0];
        end else if (s_axi_araddr == OFS_UP2_HI) begin
            rd_word = hi_word(upper2);
        end else begin
            rd_hit = 1'b0;
        end
    end

    // ----------------------------------------
    // Bus handshakes
    // ----------------------------------------
    assign s_axi_awready = !s.aw_held && !s.bvalid;
    assign s_axi_wready = !s.w_held && !s.bvalid;
    assign s_axi_arready = !s.rvalid;
    assign s_axi_bvalid = s.bvalid;
    assign s_axi_bresp = s.bresp;
    assign s_axi_rvalid = s.rvalid;
    assign s_axi_rdata = s.rdata;
    assign s_axi_rresp = s.rresp;
    assign wr_go = s.aw_held && s.w_held;
    assign wmask = {{8{s.wstrb[3]}}, {8{s.wstrb[2]}}, {8{s.wstrb[1]}}, {8{s.wstrb[0]}}};

    // ----------------------------------------
    // Next state
    // ----------------------------------------
    always_comb begin
        next_s = s;
        next_s.sw_cmd = '0;
        // Pairing monitor: a clear arms its gate, the gate consumes it
        next_s.armed = (s.armed | clr_vec) & ~gate_vec;
        if (|(gate_vec & ~s.armed)) begin
            next_s.unpaired = 1'b1;
        end
        if (|(gate_vec & clr_vec)) begin
            next_s.collide = 1'b1;
        end
        // Store data always from the accumulator
        next_s.store_valid = store_strobe_in;
        if (store_strobe_in) begin
            next_s.store_data = acc;
        end
        if (s_axi_awvalid && s_axi_awready) begin
            next_s.aw_held = 1'b1;
            next_s.awaddr = s_axi_awaddr;
        end
        if (s_axi_wvalid && s_axi_wready) begin
            next_s.w_held = 1'b1;
            next_s.wdata = s_axi_wdata;
            next_s.wstrb = s_axi_wstrb;
        end
        if (wr_go) begin
            next_s.aw_held = 1'b0;
            next_s.w_held = 1'b0;
            next_s.bvalid = 1'b1;
            next_s.bresp = RESP_OKAY;
            if (s.awaddr == OFS_CTRL) begin
                if (s.wstrb[0]) begin
                    next_s.ctrl_direct = s.wdata[CTRL_DIRECT];
                end
            end else if (s.awaddr == OFS_CMD) begin
                next_s.sw_cmd = seq_cmd_t'(s.wdata[CMD_W-1:0] & wmask[CMD_W-1:0]);
            end else if (s.awaddr == OFS_STATUS) begin
                // Write one to clear; a same-cycle event keeps the flag
                if (s.wstrb[0] && s.wdata[STAT_UNPAIRED] && !(|(gate_vec & ~s.armed))) begin
                    next_s.unpaired = 1'b0;
                end
                if (s.wstrb[0] && s.wdata[STAT_COLLIDE] && !(|(gate_vec & clr_vec))) begin
                    next_s.collide = 1'b0;
                end
            end else if (s.awaddr == OFS_ACC_LO || s.awaddr == OFS_ACC_HI || s.awaddr == OFS_UP1_LO
                         || s.awaddr == OFS_UP1_HI || s.awaddr == OFS_ARITH_LO || s.awaddr == OFS_ARITH_HI
                         || s.awaddr == OFS_UP2_LO || s.awaddr == OFS_UP2_HI) begin
                next_s.bresp = RESP_OKAY;
            end else begin
                next_s.bresp = RESP_SLVERR;
            end
        end
        if (s.bvalid && s_axi_bready) begin
            next_s.bvalid = 1'b0;
        end
        if (s_axi_arvalid && s_axi_arready) begin
            next_s.rvalid = 1'b1;
            next_s.rdata = rd_word;
            next_s.rresp = rd_hit ? RESP_OKAY : RESP_SLVERR;
        end else if (s.rvalid && s_axi_rready) begin
            next_s.rvalid = 1'b0;
        end
        if (!rstn_in) begin
            next_s = '0;
        end
    end

    always_ff @(posedge clock_in) begin
        s <= next_s;
    end

    // ----------------------------------------
    // Assertions
    // ----------------------------------------
    default clocking cb @(posedge clock_in); endclocking
    default disable iff (!rstn_in);

    logic only_entry_clr;
    logic only_copy_clr;
    logic plain_gate;
    assign only_entry_clr = eff == seq_cmd_t'(11'h400) && !tape_valid_in;
    assign only_copy_clr = eff == seq_cmd_t'(11'h200) && !tape_valid_in;
    assign plain_gate = !s.ctrl_direct && !tape_valid_in && eff_strobe;

    sequence s_right_gate;
        plain_gate && eff == seq_cmd_t'(11'h008);
    endsequence
    sequence s_left_gate;
        plain_gate && eff == seq_cmd_t'(11'h004);
    endsequence
    sequence s_right_pair;
        eff == seq_cmd_t'(11'h100) && !tape_valid_in ##1 s_right_gate;
    endsequence

    property p_entry_clear_ones;
        only_entry_clr |=> upper1 == '1;
    endproperty
    a_entry_clear_ones: assert property (p_entry_clear_ones) else $error("entry clear left zeros");

    property p_copy_clear_zeros;
        only_copy_clr |=> upper1 == '0 ##1 (upper1 == '0 || $past(eff) != '0);
    endproperty
    a_copy_clear_zeros: assert property (p_copy_clear_zeros) else $error("copy-up clear left ones");

    property p_right_shift;
        s_right_gate |=> acc == ($past(acc) | {1'b0, $past(upper1[ROW_W-1:1])});
    endproperty
    a_right_shift: assert property (p_right_shift) else $error("right shift wrong");

    property p_right_pair;
        s_right_pair |=> acc == {1'b0, $past(upper1[ROW_W-1:1])};
    endproperty
    a_right_pair: assert property (p_right_pair) else $error("clear plus right gate wrong");

    property p_left_shift;
        s_left_gate |=> acc == ($past(acc) & {$past(upper1[ROW_W-2:0]), 1'b1});
    endproperty
    a_left_shift: assert property (p_left_shift) else $error("left shift wrong");

    property p_lockstep;
        s_right_gate |=> arith == ($past(arith) | {1'b0, $past(upper2[ROW_W-1:1])});
    endproperty
    a_lockstep: assert property (p_lockstep) else $error("second pair not in lockstep");

    property p_memory_load;
        eff_strobe && eff == seq_cmd_t'(11'h001) |=> arith == $past(memory_word_in);
    endproperty
    a_memory_load: assert property (p_memory_load) else $error("memory load wrong");

    property p_tape_entry;
        tape_valid_in && eff == '0 |=> acc == {$past(acc[ROW_W-2:0]), $past(tape_bit_in)};
    endproperty
    a_tape_entry: assert property (p_tape_entry) else $error("tape bit not at low end");

    property p_store_source;
        store_strobe_in |=> mem_write_out && mem_data_out == $past(acc);
    endproperty
    a_store_source: assert property (p_store_source) else $error("store data not accumulator");

    property p_strobe_bounds;
        !eff_strobe && !tape_valid_in && (eff & seq_cmd_t'(11'h03f)) != '0
            && (eff & seq_cmd_t'(11'h7c0)) == '0 |=> $stable(acc) && $stable(upper1) && $stable(arith)
            && $stable(upper2);
    endproperty
    a_strobe_bounds: assert property (p_strobe_bounds) else $error("gate acted without strobe");

    property p_direct_copy;
        s.ctrl_direct && eff_strobe && eff == seq_cmd_t'(11'h010) |=> upper1 == $past(acc);
    endproperty
    a_direct_copy: assert property (p_direct_copy) else $error("double gating did not copy");

    property p_arith_upper_zeros;
        eff == seq_cmd_t'(11'h040) |=> upper2 == '0;
    endproperty
    a_arith_upper_zeros: assert property (p_arith_upper_zeros) else $error("upper row two not zero");

    property p_unpaired_flag;
        |(gate_vec & ~s.armed) |=> s.unpaired;
    endproperty
    a_unpaired_flag: assert property (p_unpaired_flag) else $error("unpaired gate not flagged");
endmodule // shifting_register_gating

// ---- shifting_register_gating_test.sv ----
// Purpose: Self-checking bench for the shifting double registers
// Assumes: seq_model drives clears, gates and source words
// Notes: Each row loads, copies up, enters a sum, then shifts
`timescale 1ns/1ps
module shifting_register_gating_test;
    import shift_pkg::*;
    typedef struct packed {logic [2:0] op; logic [39:0] w, m, ea, em;} row_t;
    row_t rows [4] = '{'{3'h2, 40'h8000000001, 40'h0000000003, 40'h4000000000, 40'h0000000001},
        '{3'h3, 40'h8000000001, 40'hc000000000, 40'h0000000003, 40'h8000000001},
        '{3'h2, 40'hffffffffff, 40'h5555555555, 40'h7fffffffff, 40'h2aaaaaaaaa},
        '{3'h3, 40'h123456789a, 40'haaaaaaaaaa, 40'h2468acf135, 40'h5555555555}};
    logic clock_in = 0, rstn_in = 0, go = 0, stren = 1, tv = 0, tbit = 0, st = 0, stb, mw;
    logic awv = 0, wv = 0, br = 0, arv = 0, rr = 0, awr, wr, bv, arr, rv;
    logic [2:0] op = 0;
    logic [39:0] word = 0, src, acc, ari, mdata;
    logic [7:0] aw = 0, ar = 0;
    logic [31:0] wd = 0, rd, e;
    logic [1:0] bresp, rresp, r;
    seq_cmd_t cmd;
    int miscompares = 0, n_tests = 0;
    always #2 clock_in = ~clock_in;
    seq_model seq_model_inst (.clock_in, .rstn_in, .go_in(go), .op_in(op), .strobe_en_in(stren),
        .word_in(word), .cmd_out(cmd), .strobe_out(stb), .src_word_out(src));
    shifting_register_gating shifting_register_gating_inst (.clock_in, .rstn_in, .seq_cmd_in(cmd),
        .gate_strobe_in(stb), .sum_word_in(src), .memory_word_in(src), .tape_valid_in(tv), .tape_bit_in(tbit),
        .store_strobe_in(st), .accumulator_row_out(acc), .arithmetic_row_out(ari), .mem_write_out(mw),
        .mem_data_out(mdata), .s_axi_awaddr(aw), .s_axi_awvalid(awv), .s_axi_awready(awr), .s_axi_wdata(wd),
        .s_axi_wstrb(4'hf), .s_axi_wvalid(wv), .s_axi_wready(wr), .s_axi_bresp(bresp), .s_axi_bvalid(bv),
        .s_axi_bready(br), .s_axi_araddr(ar), .s_axi_arvalid(arv), .s_axi_arready(arr), .s_axi_rdata(rd),
        .s_axi_rresp(rresp), .s_axi_rvalid(rv), .s_axi_rready(rr));
    task automatic chk(input string n, input logic [39:0] g, x);
        n_tests++;
        if (g !== x) begin
            miscompares++;
            $display("CHECK FAILED %s expected %h seen %h", n, x, g);
        end
    endtask
    task automatic results;
        $display("comparisons %0d miscompares %0d", n_tests, miscompares);
        if (miscompares == 0 && n_tests > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask
    task automatic run(input logic [2:0] o, input logic [39:0] w, input logic s);
        @(posedge clock_in);
        go <= 1;
        op <= o;
        word <= w;
        stren <= s;
        @(posedge clock_in);
        go <= 0;
        repeat (2) @(posedge clock_in);
        #1;
    endtask
    task automatic axw(input logic [7:0] a, input logic [31:0] d);
        @(posedge clock_in);
        {aw, wd, awv, wv, br} <= {a, d, 3'h7};
        do begin
            @(posedge clock_in);
            if (awr) awv <= 0;
            if (wr) wv <= 0;
        end while (!bv);
        r = bresp;
        br <= 0;
    endtask
    task automatic axr(input logic [7:0] a);
        @(posedge clock_in);
        {ar, arv, rr} <= {a, 2'h3};
        do begin
            @(posedge clock_in);
            if (arr) arv <= 0;
        end while (!rv);
        {r, e} = {rresp, rd};
        rr <= 0;
    endtask
    initial begin
        repeat (6) @(posedge clock_in);
        rstn_in <= 1;
        for (int i = 0; i < 4; i++) begin
            run(3'h5, rows[i].m, 1);
            run(3'h4, 0, 1);
            run(3'h0, rows[i].w, 1);
            run(rows[i].op, 0, 1);
            chk("accumulator", acc, rows[i].ea);
            chk("arithmetic", ari, rows[i].em);
            run(3'h1, 0, 1);
            axr(OFS_UP1_LO);
            chk("upper copy", e, rows[i].ea[31:0]);
        end
        run(3'h5, 40'h11, 0);
        chk("unstrobed gate", ari, rows[3].em);
        @(posedge clock_in);
        st <= 1;
        @(posedge clock_in);
        st <= 0;
        #1 chk("store pulse", mw, 1);
        chk("store data", mdata, rows[3].ea);
        @(posedge clock_in);
        {tv, tbit} <= 2'h3;
        @(posedge clock_in);
        tv <= 0;
        #1 chk("tape entry", acc, {rows[3].ea[38:0], 1'b1});
        axr(8'hf0);
        chk("unmapped resp", r, RESP_SLVERR);
        chk("unmapped data", e, 0);
        axw(OFS_ACC_LO, 32'h0);
        chk("read-only resp", r, RESP_OKAY);
        axw(OFS_CTRL, 32'h1);
        axw(OFS_CMD, 32'h10);
        axr(OFS_UP1_LO);
        chk("direct copy lo", e, 32'hd159e26b);
        axr(OFS_UP1_HI);
        chk("direct copy hi", e, 32'h48);
        axr(OFS_STATUS);
        chk("unpaired flag", e, 32'h1);
        axw(OFS_STATUS, 32'h1);
        axr(OFS_STATUS);
        chk("flag cleared", e, 32'h0);
        @(posedge clock_in);
        rstn_in <= 0;
        repeat (6) @(posedge clock_in);
        rstn_in <= 1;
        @(posedge clock_in);
        chk("acc reset", acc, 0);
        chk("arith reset", ari, 0);
        results;
    end
    initial begin
        repeat (3000) @(posedge clock_in);
        miscompares++;
        results;
    end
endmodule // shifting_register_gating_test
